// ===== logic/npc_consts.svh
`ifndef NPC_CONSTS_SVH
`define NPC_CONSTS_SVH
// Register offsets on the plain register port
`define NPC_OFF_OWNER 8'h0C
`define NPC_OFF_LOCK 8'h0D
`define NPC_OFF_PAGE 8'h88
`define NPC_OFF_CMD 8'h89
`define NPC_OFF_CRC 8'h8A
`define NPC_OFF_BUSY 8'h8B
`define NPC_OFF_CRCST 8'h8C
`define NPC_OFF_IRQST 8'h90
`define NPC_OFF_IRQMASK 8'h91
// Bit positions
`define NPC_BIT_IFSEL 0
`define NPC_BIT_ENGRST 1
`define NPC_BIT_LOCK 0
`define NPC_BIT_PROG 0
`define NPC_BIT_ERASE 1
`define NPC_BIT_ERPROG 2
`define NPC_BIT_FIXED 3
`define NPC_BIT_CALC 0
`define NPC_BIT_RDBUSY 0
`define NPC_BIT_ERBUSY 1
`define NPC_BIT_PGBUSY 2
`define NPC_BIT_CRCRUN 0
`define NPC_BIT_CRCGOOD 1
// Interrupt status bits
`define NPC_IRQ_OPDONE 0
`define NPC_IRQ_CRCDONE 1
`define NPC_IRQ_REFUSED 2
// Reset values
`define NPC_ZERO8 8'h00
`define NPC_ZERO4 4'h0
`define NPC_ZERO3 3'h0
// Timing: clock 20 MHz, fixed write time 8 ms
`define NPC_CLK_HZ 20000000
`define NPC_FIXED_MS 8
`define NPC_FIXED_CYC ((`NPC_CLK_HZ / 1000) * `NPC_FIXED_MS)
`define NPC_VAR_CYC_DEF (`NPC_FIXED_CYC / 2)
`define NPC_CRC_CYC_DEF 256
`define NPC_CNT_W 20
`define NPC_CNT_ONE 20'h00001
`endif

// ===== logic/npc_pkg.sv
package npc_pkg;
	// Sequencer states, one-hot
	typedef enum logic [4:0] {
		NPC_IDLE = 5'b00001,
		NPC_ERASE = 5'b00010,
		NPC_PROG = 5'b00100,
		NPC_CRC = 5'b01000,
		NPC_READ = 5'b10000
	} npc_state_type;
endpackage : npc_pkg

// ===== logic/npc_nvm_page_program_control.sv
// Strobed register access was chosen for this implementation.
`include "npc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module npc_nvm_page_program_control
	import npc_pkg::*;
#(
	parameter logic [19:0] FIXED_CYC = 20'(`NPC_FIXED_CYC), // 8 ms at 20 MHz
	parameter logic [19:0] VAR_CYC = 20'(`NPC_VAR_CYC_DEF), // Variable time, below 8 ms
	parameter logic [19:0] CRC_CYC = 20'(`NPC_CRC_CYC_DEF) // Checksum pass length
) (
	input wire logic clk, // System clock, 20 MHz
	input wire logic sys_rst, // Async reset, active high
	input wire logic [7:0] regAddr, // Register address
	input wire logic [7:0] regWrData, // Write data
	input wire logic regWr, // Write strobe
	input wire logic regRd, // Read strobe
	output logic [7:0] regRdData, // Read data, cycle after strobe
	input wire logic crcMatch, // Stored checksum equals calculated
	output logic ifOwner, // Interface owns resources
	output logic engineReset, // Compensation engine held in reset
	output logic [3:0] nvmPage, // Page under operation
	output logic nvmErase, // Erase pulse level to array
	output logic nvmProgram, // Program level to array
	output logic nvmRead, // Read level for checksum pass
	output logic irq // Level interrupt
);

	logic ownerIf_q, engRst_q, lock_q, fixedTime_q;
	logic [3:0] page_q;
	logic [2:0] cmdBits_q;
	logic calc_q;
	npc_state_type state_q;
	logic pendProg_q;
	logic [19:0] cnt_q;
	logic crcGood_q;
	logic [2:0] irqSt_q, irqMask_q;
	logic [7:0] rdData_q;
	logic wrOwner, wrLock, wrPage, wrCmd, wrCrc, wrIrqSt, wrIrqMask;
	logic idle, lastCycle, launchCmd, launchCrc, refuse;
	logic opDone, crcDone;
	logic [19:0] opLen;

	// Overview of the block
	// The host reaches every register through one plain port.
	// Writes take effect at the edge that samples the strobe.
	// Reads are registered, so data stands one cycle later.
	// Only one array operation runs at any time.
	// The sequencer owns the array strobes and the busy flags.
	// Commands land in small pending registers first.
	// A pending command launches only from the idle state.
	// Launch clears the pending bit, so a new write starts anew.
	// The lock blocks new launches but never aborts a running one.
	// Aborting mid-erase would leave a page half cleared.
	// Timing is counted in clock cycles, not in wall time.
	// The fixed time is derived from the clock rate.
	// The variable time is a parameter kept below the fixed one.
	// The checksum pass reads the array for a set number of cycles.
	// A compare cycle follows, sampling the match line once.
	// The match line is only meaningful in that compare cycle.
	// Events feed a sticky status with a mask beside it.
	// The interrupt is a level, registered one cycle late.
	// All outputs come from flip-flops to keep pins glitch free.

	// Hazards kept in mind
	// A clear and a new event in one cycle: the event wins.
	// Losing an event would hide a finished operation forever.
	// Two command bits at once: erase outranks program.
	// Erase first keeps the array in a known state.
	// A command written while busy waits, it is not lost.
	// The host is still asked to wait for idle before writing.
	// Refused writes raise a status bit so software can notice.

	// Write address decode
	// One decoded strobe per writable register; unmapped writes go nowhere.
	// Decoding is fully combinational, so strobes align with the bus.
	always_comb begin
		wrOwner = 1'b0;
		wrLock = 1'b0;
		wrPage = 1'b0;
		wrCmd = 1'b0;
		wrCrc = 1'b0;
		wrIrqSt = 1'b0;
		wrIrqMask = 1'b0;
		if (regWr && regAddr == `NPC_OFF_OWNER) begin
			wrOwner = 1'b1;
		end else if (regWr && regAddr == `NPC_OFF_LOCK) begin
			wrLock = 1'b1;
		end else if (regWr && regAddr == `NPC_OFF_PAGE) begin
			wrPage = 1'b1;
		end else if (regWr && regAddr == `NPC_OFF_CMD) begin
			wrCmd = 1'b1;
		end else if (regWr && regAddr == `NPC_OFF_CRC) begin
			wrCrc = 1'b1;
		end else if (regWr && regAddr == `NPC_OFF_IRQST) begin
			wrIrqSt = 1'b1;
		end else if (regWr && regAddr == `NPC_OFF_IRQMASK) begin
			wrIrqMask = 1'b1;
		end
	end

	// Launch conditions; commands seen while locked are dropped, while busy they wait
	// Launch needs idle and no lock, plus a pending bit.
	// Checksum waits for array commands, which take priority.
	// Refuse flags any attempt to start work under the lock.
	// The op length is chosen when the operation is loaded.
	assign idle = (state_q == NPC_IDLE);
	assign launchCmd = idle && !lock_q && (cmdBits_q != `NPC_ZERO3);
	assign launchCrc = idle && !lock_q && calc_q && (cmdBits_q == `NPC_ZERO3);
	assign refuse = (wrCmd && lock_q
		&& (regWrData[`NPC_BIT_ERPROG:`NPC_BIT_PROG] != `NPC_ZERO3))
		|| (wrCrc && lock_q && regWrData[`NPC_BIT_CALC]);
	assign lastCycle = (cnt_q == `NPC_CNT_ONE);
	assign opLen = fixedTime_q ? FIXED_CYC : VAR_CYC;

	// Owner control register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ownerIf_q <= 1'b0;
			engRst_q <= 1'b0;
		end else if (wrOwner) begin
			ownerIf_q <= regWrData[`NPC_BIT_IFSEL];
			engRst_q <= regWrData[`NPC_BIT_ENGRST];
		end
	end

	// Lock register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lock_q <= 1'b0;
		end else if (wrLock) begin
			lock_q <= regWrData[`NPC_BIT_LOCK];
		end
	end

	// Page pointer; upper bits are dropped
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			page_q <= `NPC_ZERO4;
		end else if (wrPage) begin
			page_q <= regWrData[3:0];
		end
	end

	// Command bits: set by write of one, cleared on launch
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cmdBits_q <= `NPC_ZERO3;
			fixedTime_q <= 1'b0;
		end else if (wrCmd) begin
			// Writing zero leaves pending bits alone
			cmdBits_q <= (launchCmd ? `NPC_ZERO3 : cmdBits_q)
				| (lock_q ? `NPC_ZERO3 : regWrData[`NPC_BIT_ERPROG:`NPC_BIT_PROG]);
			fixedTime_q <= regWrData[`NPC_BIT_FIXED];
		end else if (launchCmd) begin
			cmdBits_q <= `NPC_ZERO3;
		end
	end

	// Checksum trigger bit
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			calc_q <= 1'b0;
		end else if (wrCrc && regWrData[`NPC_BIT_CALC] && !lock_q) begin
			calc_q <= 1'b1;
		end else if (launchCrc) begin
			calc_q <= 1'b0;
		end
	end

	// Operation sequencer; erase-and-program runs erase then program
	// Each busy state loads the counter on entry.
	// The counter runs down to one, then the state moves on.
	// So a state loaded with N stays exactly N cycles.
	// The combined operation reloads the counter for its program half.
	// The read state feeds the checksum; the compare state follows.
	// Unknown codes fall back to idle as a safety net.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= NPC_IDLE;
			pendProg_q <= 1'b0;
			cnt_q <= 20'h00000;
		end else begin
			case (state_q)
				NPC_IDLE: begin
					if (launchCmd && (cmdBits_q[`NPC_BIT_ERASE] || cmdBits_q[`NPC_BIT_ERPROG])) begin
						state_q <= NPC_ERASE;
						pendProg_q <= cmdBits_q[`NPC_BIT_ERPROG];
						cnt_q <= opLen;
					end else if (launchCmd) begin
						state_q <= NPC_PROG;
						cnt_q <= opLen;
					end else if (launchCrc) begin
						state_q <= NPC_READ;
						cnt_q <= CRC_CYC;
					end
				end
				NPC_ERASE: begin
					if (lastCycle && pendProg_q) begin
						state_q <= NPC_PROG;
						pendProg_q <= 1'b0;
						cnt_q <= opLen;
					end else if (lastCycle) begin
						state_q <= NPC_IDLE;
					end else begin
						cnt_q <= cnt_q - `NPC_CNT_ONE;
					end
				end
				NPC_PROG: begin
					if (lastCycle) begin
						state_q <= NPC_IDLE;
					end else begin
						cnt_q <= cnt_q - `NPC_CNT_ONE;
					end
				end
				NPC_READ: begin
					// Memory read pass feeds the checksum; compare follows
					if (lastCycle) begin
						state_q <= NPC_CRC;
					end else begin
						cnt_q <= cnt_q - `NPC_CNT_ONE;
					end
				end
				NPC_CRC: begin
					state_q <= NPC_IDLE;
				end
				default: begin
					state_q <= NPC_IDLE;
				end
			endcase
		end
	end

	// Checksum result latched at the end of the pass
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			crcGood_q <= 1'b0;
		end else if (state_q == NPC_CRC) begin
			crcGood_q <= crcMatch;
		end
	end

	// Events
	assign opDone = lastCycle && (state_q == NPC_PROG || (state_q == NPC_ERASE && !pendProg_q));
	assign crcDone = (state_q == NPC_CRC);

	// Interrupt status: set wins over write-one-to-clear
	// Bit 0 marks a finished erase or program operation.
	// Bit 1 marks a finished checksum pass.
	// Bit 2 marks a command refused under the lock.
	// The mask has the same layout; only unmasked bits raise irq.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irqSt_q <= `NPC_ZERO3;
			irqMask_q <= `NPC_ZERO3;
		end else begin
			irqSt_q <= (irqSt_q & ~(wrIrqSt ? regWrData[2:0] : `NPC_ZERO3))
				| {refuse, crcDone, opDone};
			if (wrIrqMask) begin
				irqMask_q <= regWrData[2:0];
			end
		end
	end

	// Read data, valid the cycle after the strobe; unmapped reads zero
	// Reading zero elsewhere keeps the bus free of stale values.
	// Busy and running flags come straight from the state register.
	// Status reads have no side effects; clears need a write.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdData_q <= `NPC_ZERO8;
		end else if (regRd && regAddr == `NPC_OFF_OWNER) begin
			rdData_q <= {6'h00, engRst_q, ownerIf_q};
		end else if (regRd && regAddr == `NPC_OFF_LOCK) begin
			rdData_q <= {7'h00, lock_q};
		end else if (regRd && regAddr == `NPC_OFF_PAGE) begin
			rdData_q <= {4'h0, page_q};
		end else if (regRd && regAddr == `NPC_OFF_CMD) begin
			rdData_q <= {4'h0, fixedTime_q, cmdBits_q};
		end else if (regRd && regAddr == `NPC_OFF_CRC) begin
			rdData_q <= {7'h00, calc_q};
		end else if (regRd && regAddr == `NPC_OFF_BUSY) begin
			rdData_q <= {5'h00, state_q == NPC_PROG, state_q == NPC_ERASE,
				state_q == NPC_READ};
		end else if (regRd && regAddr == `NPC_OFF_CRCST) begin
			rdData_q <= {6'h00, crcGood_q, state_q == NPC_READ || state_q == NPC_CRC};
		end else if (regRd && regAddr == `NPC_OFF_IRQST) begin
			rdData_q <= {5'h00, irqSt_q};
		end else if (regRd && regAddr == `NPC_OFF_IRQMASK) begin
			rdData_q <= {5'h00, irqMask_q};
		end else begin
			rdData_q <= `NPC_ZERO8;
		end
	end

	// Registered outputs; array strobes lag state by one cycle
	// The lag is traded for clean, glitch-free array controls.
	// The page copy lags the register by one cycle as well.
	// Software reads busy back at the same edge the array strobe rises.
	// The compare cycle still sees the read strobe high through the lag.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			nvmPage <= `NPC_ZERO4;
			nvmErase <= 1'b0;
			nvmProgram <= 1'b0;
			nvmRead <= 1'b0;
			irq <= 1'b0;
		end else begin
			nvmPage <= page_q;
			nvmErase <= (state_q == NPC_ERASE);
			nvmProgram <= (state_q == NPC_PROG);
			nvmRead <= (state_q == NPC_READ);
			irq <= |(irqSt_q & irqMask_q);
		end
	end

	assign regRdData = rdData_q;
	assign ifOwner = ownerIf_q;
	assign engineReset = engRst_q;

endmodule : npc_nvm_page_program_control
`default_nettype wire

// ===== sim/npc_nvm_sva.sv
`timescale 1ns/1ps
`default_nettype none
module npc_nvm_sva #(
	parameter logic [19:0] FIXED_CYC = 20'h00014 // Fixed time
) (
	input wire logic clk, // Clock
	input wire logic sys_rst, // Reset
	input wire logic [7:0] regAddr, // Address
	input wire logic [7:0] regWrData, // Data
	input wire logic regWr, // Write
	input wire logic ifOwner, // Owner
	input wire logic engineReset, // Engine hold
	input wire logic [3:0] nvmPage, // Page
	input wire logic nvmErase, // Erase
	input wire logic nvmProgram, // Program
	input wire logic nvmRead // Read
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic lock_q;
	logic [19:0] eraseLen_q;
	logic [19:0] progLen_q;
	wire logic busy = nvmErase | nvmProgram | nvmRead;
	// Lock mirror, so launches can be predicted from the port alone
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) lock_q <= 1'b0;
		else if (regWr && regAddr == 8'h0D) lock_q <= regWrData[0];
	end
	// Level lengths of erase and program
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			eraseLen_q <= 20'h00000;
			progLen_q <= 20'h00000;
		end else begin
			eraseLen_q <= nvmErase ? eraseLen_q + 20'h00001 : 20'h00000;
			progLen_q <= nvmProgram ? progLen_q + 20'h00001 : 20'h00000;
		end
	end
	// Pending commands would spoil a launch prediction, so demand quiet first
	sequence quietS;
		(!busy && !(regWr && (regAddr == 8'h89 || regAddr == 8'h8A)))[*3];
	endsequence
	sequence cmdS(logic [2:0] c);
		regWr && regAddr == 8'h89 && regWrData[2:0] == c && !lock_q;
	endsequence
	a_prog_launch: assert property (quietS ##1 cmdS(3'b001) |-> ##[1:3] nvmProgram)
		else $error("program not launched");
	a_erase_launch: assert property (quietS ##1 cmdS(3'b010) |-> ##[1:3] nvmErase)
		else $error("erase not launched");
	a_erase_then_prog: assert property (quietS ##1 cmdS(3'b100)
		|-> ##[1:3] (nvmErase && !nvmProgram) ##[1:30] ($fell(nvmErase) && nvmProgram))
		else $error("erase then program order wrong");
	a_lock_refuse: assert property (quietS ##1 (regWr && regAddr == 8'h89
		&& regWrData[2:0] != 3'h0 && lock_q) |=> (!nvmErase && !nvmProgram)[*4])
		else $error("locked memory was accessed");
	a_crc_launch: assert property (quietS ##1 (regWr && regAddr == 8'h8A
		&& regWrData[0] && !lock_q) |-> ##[1:3] nvmRead)
		else $error("checksum not launched");
	a_read_len: assert property ($rose(nvmRead) |-> nvmRead[*8] ##1 !nvmRead)
		else $error("checksum read length wrong");
	a_op_excl: assert property (!(nvmErase && nvmProgram) && !(nvmRead && busy && !(nvmRead
		&& !nvmErase && !nvmProgram))) else $error("two operations at once");
	a_run_bound: assert property (eraseLen_q <= FIXED_CYC && progLen_q <= FIXED_CYC)
		else $error("operation too long");
	a_owner_bits: assert property (regWr && regAddr == 8'h0C |=>
		ifOwner == $past(regWrData[0]) && engineReset == $past(regWrData[1]))
		else $error("owner pins wrong");
	a_page_copy: assert property (regWr && regAddr == 8'h88 |-> ##2
		nvmPage == $past(regWrData[3:0], 2)) else $error("page pin wrong");
endmodule : npc_nvm_sva
`default_nettype wire

// ===== sim/npc_nvm_partner.sv
`timescale 1ns/1ps
`default_nettype none
module npc_nvm_partner (
	input wire logic clk, // Clock
	input wire logic nvmRead, // Pass running
	input wire logic storedGood, // Stored sum matches
	output logic crcMatch // Compare line
);
	logic noise_q = 1'b0;
	// Outside a pass the line means nothing, so it toggles
	always_ff @(posedge clk) begin
		noise_q <= ~noise_q;
	end
	assign crcMatch = nvmRead ? storedGood : noise_q;
endmodule : npc_nvm_partner
`default_nettype wire

// ===== sim/npc_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0, sys_rst = 1'b1, regWr = 1'b0, regRd = 1'b0, storedGood = 1'b1;
	logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, v;
	logic crcMatch, ifOwner, engineReset, nvmErase, nvmProgram, nvmRead, irq;
	logic [3:0] nvmPage;
	logic [7:0] offs[9] = '{8'h0C, 8'h0D, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h90, 8'h55};
	logic [7:0] cmds[6] = '{8'h01, 8'h02, 8'h04, 8'h09, 8'h0A, 8'h0C};
	int badCount = 0, totalChecks = 0, cyc = 0, eraseCnt = 0, progCnt = 0, readCnt = 0, e0;
	always #25 clk = ~clk;
	npc_nvm_page_program_control #(.FIXED_CYC(20'h00014), .VAR_CYC(20'h0000A),
		.CRC_CYC(20'h00008)) dut_u (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.crcMatch(crcMatch), .ifOwner(ifOwner), .engineReset(engineReset), .nvmPage(nvmPage),
		.nvmErase(nvmErase), .nvmProgram(nvmProgram), .nvmRead(nvmRead), .irq(irq));
	npc_nvm_partner mem_u (.clk(clk), .nvmRead(nvmRead), .storedGood(storedGood),
		.crcMatch(crcMatch));
	// Level counters and the hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		eraseCnt <= eraseCnt + int'(nvmErase === 1'b1);
		progCnt <= progCnt + int'(nvmProgram === 1'b1);
		readCnt <= readCnt + int'(nvmRead === 1'b1);
		if (cyc == 20000) begin
			badCount++;
			tally_and_finish();
		end
	end
	task tally_and_finish;
		$display("checks %0d errors %0d", totalChecks, badCount);
		if (badCount == 0 && totalChecks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : tally_and_finish
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		totalChecks++;
		if (got !== exp) begin
			badCount++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		@(negedge clk);
		chk(what, exp, regRdData);
	endtask : rd
	// Host waits for all busy levels to drop before the next command
	task waitIdle;
		int n;
		n = 0;
		repeat (4) @(negedge clk);
		while (n < 200 && (nvmErase | nvmProgram | nvmRead) !== 1'b0) begin
			@(negedge clk);
			n++;
		end
		repeat (2) @(negedge clk);
	endtask : waitIdle
	task runCmd(input logic [7:0] c);
		int e, p, len;
		len = c[3] ? 20 : 10;
		e = eraseCnt;
		p = progCnt;
		wr(8'h89, c);
		rd(8'h8B, (c[1] | c[2]) ? 8'h02 : 8'h04, "busy");
		waitIdle();
		chk("erase len", 8'((c[1] | c[2]) ? len : 0), 8'(eraseCnt - e));
		chk("prog len", 8'((c[0] | c[2]) ? len : 0), 8'(progCnt - p));
		chk("irq", 8'h01, {7'h00, irq});
		rd(8'h90, 8'h01, "irq status");
		wr(8'h90, 8'h01);
		rd(8'h89, c & 8'h08, "cmd cleared");
		chk("irq cleared", 8'h00, {7'h00, irq});
	endtask : runCmd
	initial begin
		void'($urandom(81));
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		foreach (offs[i]) rd(offs[i], 8'h00, "reset value");
		// Random owner and page values
		repeat (6) begin
			v = 8'($urandom);
			wr(8'h0C, v);
			rd(8'h0C, v & 8'h03, "owner");
			chk("owner pins", {6'h00, v[1:0]}, {6'h00, engineReset, ifOwner});
			wr(8'h88, v);
			rd(8'h88, v & 8'h0F, "page");
			chk("page pin", {4'h0, v[3:0]}, {4'h0, nvmPage});
		end
		wr(8'h91, 8'h01);
		foreach (cmds[i]) runCmd(cmds[i]);
		// Checksum with a matching and a differing stored sum; its event is masked
		for (int g = 1; g >= 0; g--) begin
			storedGood <= g[0];
			e0 = readCnt;
			wr(8'h8A, 8'h01);
			rd(8'h8C, {6'h00, ~g[0], 1'b1}, "crc running");
			waitIdle();
			chk("read len", 8'h08, 8'(readCnt - e0));
			rd(8'h8C, {6'h00, g[0], 1'b0}, "crc good");
			rd(8'h8A, 8'h00, "crc cleared");
			rd(8'h90, 8'h02, "crc event");
			chk("irq masked", 8'h00, {7'h00, irq});
			wr(8'h90, 8'h02);
		end
		// Locked memory refuses an erase
		wr(8'h0D, 8'h01);
		rd(8'h0D, 8'h01, "lock");
		e0 = eraseCnt;
		wr(8'h89, 8'h02);
		rd(8'h8B, 8'h00, "locked busy");
		chk("locked erase", 8'h00, 8'(eraseCnt - e0));
		rd(8'h90, 8'h04, "refused");
		wr(8'h90, 8'h04);
		wr(8'h0D, 8'h00);
		tally_and_finish();
	end
endmodule : tb
bind npc_nvm_page_program_control npc_nvm_sva #(.FIXED_CYC(20'h00014)) chk_u (.clk(clk),
	.sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
	.ifOwner(ifOwner), .engineReset(engineReset), .nvmPage(nvmPage), .nvmErase(nvmErase),
	.nvmProgram(nvmProgram), .nvmRead(nvmRead));
`default_nettype wire
